//--- rtl/i2c_link_timing.sv
module i2c_link_timing
    import i2c_timing_pkg::*;
#(
    parameter int LINK_STEP = LINK_STEP_CYC,
    parameter int BUS_SLOW  = BUS_SLOW_CYC,
    parameter int BUS_FAST  = BUS_FAST_CYC
) (
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic       CE,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic       REG_REMOTE,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic            REG_WR_REJECT,
    input  wire logic       LINK_TXN_ACTIVE,
    output logic            LINK_TXN_ABORT,
    input  wire logic       PROXY_MASTER_EN,
    input  wire logic       MASTER_REQ,
    input  wire logic       MASTER_REMOTE,
    input  wire logic       SLV_ACTIVE,
    input  wire logic       SLV_SDA,
    input  wire logic       SLV_ACK,
    input  wire logic       SCL_I,
    input  wire logic       SDA_I,
    output logic            SCL_O,
    output logic            SCL_OE,
    output logic            SDA_O,
    output logic            SDA_OE,
    output logic            SCL_IN,
    output logic            SDA_IN,
    output logic            BUS_FREE
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] wdog_q, wdog_d, ctl1_q, ctl1_d, ctl2_q, ctl2_d;
    logic [7:0] sclh_q, sclh_d, scll_q, scll_d, rdata_q, rdata_d;
    logic       reject_q, reject_d;

    always_comb begin
        wdog_d   = wdog_q;
        ctl1_d   = ctl1_q;
        ctl2_d   = ctl2_q;
        sclh_d   = sclh_q;
        scll_d   = scll_q;
        reject_d = 1'b0;
        rdata_d  = rdata_q;
        if (REG_WR && REG_REMOTE && ctl1_q[LOCK_BIT]) begin
            reject_d = 1'b1;
        end else if (REG_WR) begin
            unique case (REG_ADDR)
                ADDR_LINK_WDOG: wdog_d = REG_WDATA;
                ADDR_CTL1:      ctl1_d = REG_WDATA;
                ADDR_CTL2:      ctl2_d = REG_WDATA;
                ADDR_SCL_HIGH:  sclh_d = REG_WDATA;
                ADDR_SCL_LOW:   scll_d = REG_WDATA;
                default:        reject_d = 1'b0;
            endcase
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_LINK_WDOG: rdata_d = wdog_q;
                ADDR_CTL1:      rdata_d = ctl1_q;
                ADDR_CTL2:      rdata_d = ctl2_q;
                ADDR_SCL_HIGH:  rdata_d = sclh_q;
                ADDR_SCL_LOW:   rdata_d = scll_q;
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    assign REG_RDATA     = rdata_q;
    assign REG_WR_REJECT = reject_q;

    // ------------------------------------------------------------
    // oscillator tick and link watchdog
    // ------------------------------------------------------------
    logic [3:0]  osc_q, osc_d;
    logic        tick;
    logic [31:0] step_q, step_d;
    logic [6:0]  unit_q, unit_d;
    logic        abort_q, abort_d;
    logic [6:0]  tmo;

    assign tick = (osc_q == 4'(OSC_DIV - 1));
    assign tmo  = wdog_q[7:TMO_LSB];

    always_comb begin
        osc_d   = tick ? 4'h0 : osc_q + 4'h1;
        step_d  = step_q;
        unit_d  = unit_q;
        abort_d = 1'b0;
        if (!LINK_TXN_ACTIVE || wdog_q[TMO_OFF]) begin
            step_d = 32'h0;
            unit_d = 7'h00;
        end else if (step_q == 32'(LINK_STEP - 1)) begin
            step_d = 32'h0;
            unit_d = unit_q + 7'h01;
            if (unit_q + 7'h01 == tmo) begin
                abort_d = 1'b1;
                unit_d  = 7'h00;
            end
        end else begin
            step_d = step_q + 32'h1;
        end
    end

    assign LINK_TXN_ABORT = abort_q;

    // ------------------------------------------------------------
    // input filtering and SDA hold
    // ------------------------------------------------------------
    logic       scl_f, sda_f, scl_p_q, sda_p_q, sda_in_q, sda_in_d;
    logic [2:0] hold_q, hold_d;
    logic       scl_fall, activity;

    pin_glitch_filter u_scl_filt (
        .clk   (CLK),
        .srst  (SRST),
        .ce    (CE),
        .din   (SCL_I),
        .depth (ctl1_q[FILT_LSB +: 4]),
        .dout  (scl_f)
    );
    pin_glitch_filter u_sda_filt (
        .clk   (CLK),
        .srst  (SRST),
        .ce    (CE),
        .din   (SDA_I),
        .depth (ctl1_q[FILT_LSB +: 4]),
        .dout  (sda_f)
    );

    assign scl_fall = scl_p_q && !scl_f;
    assign activity = (scl_p_q != scl_f) || (sda_p_q != sda_f);

    always_comb begin
        hold_d   = hold_q;
        sda_in_d = sda_in_q;
        if (scl_fall) begin
            hold_d = ctl1_q[HOLD_LSB +: 3];
        end else if (hold_q != 3'h0) begin
            hold_d = tick ? hold_q - 3'h1 : hold_q;
        end else begin
            sda_in_d = sda_f;
        end
    end

    assign SCL_IN = scl_p_q;
    assign SDA_IN = sda_in_q;

    // ------------------------------------------------------------
    // bus watchdog
    // ------------------------------------------------------------
    logic [31:0] idle_q, idle_d, idle_lim;
    logic        free_q, free_d;
    logic [3:0]  rec_q, rec_d;
    logic        expire;

    assign idle_lim = ctl2_q[FAST_BIT] ? 32'(BUS_FAST) : 32'(BUS_SLOW);
    assign expire   = (idle_q >= idle_lim - 32'h1);

    // ------------------------------------------------------------
    // master SCL generator
    // ------------------------------------------------------------
    mst_state_t mst_q, mst_d;
    logic [8:0] mcnt_q, mcnt_d;
    logic       mst_go;

    assign mst_go = MASTER_REQ && (!MASTER_REMOTE || PROXY_MASTER_EN);

    always_comb begin
        idle_d = idle_q + 32'h1;
        free_d = free_q;
        rec_d  = rec_q;
        if (activity || ctl2_q[BWD_OFF]) begin
            idle_d = 32'h0;
            free_d = 1'b0;
        end else if (expire) begin
            idle_d = 32'h0;
            if (sda_f) begin
                free_d = 1'b1;
            end else if (rec_q == 4'h0) begin
                rec_d = RECOVER_PULSES;
            end
        end
        mst_d  = mst_q;
        mcnt_d = (tick && mcnt_q != 9'h0) ? mcnt_q - 9'h1 : mcnt_q;
        unique case (mst_q)
            M_IDLE: begin
                if (mst_go || rec_q != 4'h0) begin
                    mst_d  = M_LOW;
                    mcnt_d = 9'(scll_q) + 9'(SCL_EXTRA);
                end
            end
            M_LOW: begin
                if (tick && mcnt_q == 9'h1) begin
                    mst_d  = M_HIGH;
                    mcnt_d = 9'(sclh_q) + 9'(SCL_EXTRA);
                end
            end
            M_HIGH: begin
                if (tick && mcnt_q == 9'h1) begin
                    if (rec_q != 4'h0) begin
                        rec_d = rec_q - 4'h1;
                    end
                    mst_d = M_IDLE;
                end
            end
            default: mst_d = M_IDLE;
        endcase
    end

    assign BUS_FREE = free_q;

    // ------------------------------------------------------------
    // slave SDA output timing and clock stretch
    // ------------------------------------------------------------
    slv_state_t slv_q, slv_d;
    logic [8:0] scnt_q, scnt_d, dly_t, setup_t, low_t;
    logic       sda_low_q, sda_low_d;

    assign dly_t   = ns_ticks(DLY_BASE_NS + DLY_STEP_NS
                              * int'(ctl2_q[DLY_LSB +: 2]));
    assign setup_t = ns_ticks(SETUP_BASE_NS + SETUP_STEP_NS
                              * int'(ctl2_q[SETUP_LSB +: 4]));
    assign low_t   = 9'(scll_q) + 9'(SCL_EXTRA);

    always_comb begin
        slv_d     = slv_q;
        sda_low_d = SLV_ACTIVE ? sda_low_q : 1'b0;
        scnt_d    = (tick && scnt_q != 9'h0) ? scnt_q - 9'h1 : scnt_q;
        unique case (slv_q)
            S_IDLE: begin
                if (SLV_ACTIVE && scl_fall) begin
                    slv_d  = S_DELAY;
                    scnt_d = dly_t;
                end
            end
            S_DELAY: begin
                if (tick && scnt_q <= 9'h1) begin
                    slv_d     = S_SETUP;
                    sda_low_d = SLV_ACTIVE && !SLV_SDA;
                    scnt_d    = SLV_ACK ? setup_t : low_t;
                end
            end
            S_SETUP: begin
                if (tick && scnt_q <= 9'h1) begin
                    slv_d = S_IDLE;
                end
            end
            default: slv_d = S_IDLE;
        endcase
    end

    assign SCL_O  = 1'b0;
    assign SDA_O  = 1'b0;
    assign SCL_OE = (mst_q == M_LOW) || (slv_q != S_IDLE);
    assign SDA_OE = sda_low_q;

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            wdog_q <= RST_LINK_WDOG;
            ctl1_q <= RST_CTL1;
            ctl2_q <= RST_CTL2;
            sclh_q <= RST_SCL_PERIOD;
            scll_q <= RST_SCL_PERIOD;
            rdata_q <= 8'h00;
            reject_q <= 1'b0;
            osc_q <= 4'h0;
            step_q <= 32'h0;
            unit_q <= 7'h00;
            abort_q <= 1'b0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sda_in_q <= 1'b1;
            hold_q <= 3'h0;
            idle_q <= 32'h0;
            free_q <= 1'b0;
            rec_q <= 4'h0;
            mst_q <= M_IDLE;
            mcnt_q <= 9'h0;
            slv_q <= S_IDLE;
            scnt_q <= 9'h0;
            sda_low_q <= 1'b0;
        end else if (CE) begin
            wdog_q <= wdog_d;
            ctl1_q <= ctl1_d;
            ctl2_q <= ctl2_d;
            sclh_q <= sclh_d;
            scll_q <= scll_d;
            rdata_q <= rdata_d;
            reject_q <= reject_d;
            osc_q <= osc_d;
            step_q <= step_d;
            unit_q <= unit_d;
            abort_q <= abort_d;
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
            sda_in_q <= sda_in_d;
            hold_q <= hold_d;
            idle_q <= idle_d;
            free_q <= free_d;
            rec_q <= rec_d;
            mst_q <= mst_d;
            mcnt_q <= mcnt_d;
            slv_q <= slv_d;
            scnt_q <= scnt_d;
            sda_low_q <= sda_low_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_fall_seen;
        CE && slv_q == S_IDLE && SLV_ACTIVE && scl_fall;
    endsequence

    sequence s_ack_ready;
        CE && slv_q == S_DELAY && tick && scnt_q <= 9'h1 && SLV_ACK;
    endsequence

    a_abort_cause: assert property (
        CE && abort_d |-> LINK_TXN_ACTIVE && unit_q + 7'h01 == tmo)
        else $error("link abort without timeout");
    a_wdog_off_quiet: assert property (
        CE && wdog_q[TMO_OFF] |=> !LINK_TXN_ABORT)
        else $error("link abort while watchdog off");
    a_remote_lock: assert property (
        CE && REG_WR && REG_REMOTE && ctl1_q[LOCK_BIT]
        |=> REG_WR_REJECT && $stable(ctl1_q) && $stable(scll_q))
        else $error("remote write passed lockout");
    a_sda_hold: assert property (
        CE && !scl_fall && hold_q != 3'h0 |=> $stable(sda_in_q))
        else $error("sda moved inside hold window");
    a_expiry_bound: assert property (
        $stable(idle_lim) |-> idle_q < idle_lim)
        else $error("bus idle count past expiry");
    a_free_high: assert property (
        CE && !free_q && free_d |-> sda_f && !ctl2_q[BWD_OFF])
        else $error("bus free with sda low");
    a_recover_nine: assert property (
        CE && rec_q == 4'h0 && rec_d != 4'h0 |=> rec_q == RECOVER_PULSES)
        else $error("recovery not nine pulses");
    a_scl_high_len: assert property (
        CE && mst_q == M_LOW && mst_d == M_HIGH
        |=> mcnt_q == 9'(sclh_q) + 9'(SCL_EXTRA))
        else $error("scl high length wrong");
    a_scl_low_len: assert property (
        CE && mst_q == M_IDLE && mst_d == M_LOW
        |=> mst_q == M_LOW && mcnt_q == low_t ##1 SCL_OE)
        else $error("scl low length wrong");
    a_out_delay: assert property (
        s_fall_seen |=> slv_q == S_DELAY && scnt_q == $past(dly_t) && SCL_OE)
        else $error("sda output delay wrong");
    a_ack_setup: assert property (
        s_ack_ready |=> slv_q == S_SETUP && scnt_q == $past(setup_t))
        else $error("ack setup wrong");
    a_data_setup: assert property (
        CE && slv_q == S_DELAY && slv_d == S_SETUP && !SLV_ACK
        |=> scnt_q == $past(low_t))
        else $error("data setup not scl low time");
    a_proxy_block: assert property (
        CE && mst_q == M_IDLE && rec_q == 4'h0 && MASTER_REQ
        && MASTER_REMOTE && !PROXY_MASTER_EN |=> mst_q == M_IDLE)
        else $error("proxy master ran while blocked");
endmodule

//--- rtl/i2c_timing_pkg.sv
package i2c_timing_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LINK_WDOG  = 8'h07;
    localparam logic [7:0] ADDR_CTL1       = 8'h08;
    localparam logic [7:0] ADDR_CTL2       = 8'h09;
    localparam logic [7:0] ADDR_SCL_HIGH   = 8'h0a;
    localparam logic [7:0] ADDR_SCL_LOW    = 8'h0b;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LINK_WDOG   = 8'hfe;
    localparam logic [7:0] RST_CTL1        = 8'h1c;
    localparam logic [7:0] RST_CTL2        = 8'h10;
    localparam logic [7:0] RST_SCL_PERIOD  = 8'h7a;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TMO_LSB   = 1;
    localparam int TMO_OFF   = 0;
    localparam int LOCK_BIT  = 7;
    localparam int HOLD_LSB  = 4;
    localparam int FILT_LSB  = 0;
    localparam int SETUP_LSB = 4;
    localparam int DLY_LSB   = 2;
    localparam int FAST_BIT  = 1;
    localparam int BWD_OFF   = 0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int OSC_PERIOD_NS  = 40;
    localparam int OSC_DIV        = OSC_PERIOD_NS * 1000 / CLK_PERIOD_PS;
    localparam int FILT_STEP_PS   = 5000;
    localparam int LINK_STEP_MS   = 2;
    localparam int LINK_STEP_CYC  = LINK_STEP_MS * 1000000 / 4;
    localparam int BUS_SLOW_US    = 1000000;
    localparam int BUS_FAST_US    = 50;
    localparam int BUS_SLOW_CYC   = BUS_SLOW_US * 1000 / 4;
    localparam int BUS_FAST_CYC   = BUS_FAST_US * 1000000 / CLK_PERIOD_PS;
    localparam int DLY_BASE_NS    = 240;
    localparam int DLY_STEP_NS    = 40;
    localparam int SETUP_BASE_NS  = 80;
    localparam int SETUP_STEP_NS  = 640;
    localparam int SCL_EXTRA      = 4;
    localparam logic [3:0] RECOVER_PULSES = 4'h9;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_LOW  = 2'b01,
        M_HIGH = 2'b10
    } mst_state_t;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_DELAY = 2'b01,
        S_SETUP = 2'b10
    } slv_state_t;

    // glitch width in clock cycles, rounded up
    function automatic logic [4:0] filt_cycles(input logic [3:0] depth);
        int ps;
        ps = int'(depth) * FILT_STEP_PS + CLK_PERIOD_PS - 1;
        return 5'(ps / CLK_PERIOD_PS);
    endfunction

    function automatic logic [8:0] ns_ticks(input int ns);
        return 9'(ns / OSC_PERIOD_NS);
    endfunction
endpackage

//--- rtl/pin_glitch_filter.sv
module pin_glitch_filter
    import i2c_timing_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       din,
    input  wire logic [3:0] depth,
    output logic            dout
);
    // ------------------------------------------------------------
    // two-stage synchroniser and stability counter
    // ------------------------------------------------------------
    logic       s1_q;
    logic       s2_q;
    logic       out_q;
    logic       out_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [4:0] lim;

    assign lim  = filt_cycles(depth);
    assign dout = out_q;

    always_comb begin
        out_d = out_q;
        cnt_d = 5'h00;
        if (s2_q != out_q) begin
            if (cnt_q >= lim) begin
                out_d = s2_q;
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            out_q <= 1'b1;
            cnt_q <= 5'h00;
        end else if (ce) begin
            s1_q  <= din;
            s2_q  <= s1_q;
            out_q <= out_d;
            cnt_q <= cnt_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_glitch_reject: assert property (
        ce && out_d != out_q |-> cnt_q >= lim && s2_q != out_q)
        else $error("filter output moved before glitch width");
endmodule

//--- tb/i2c_bus_partner.sv
// --------
// local bus: pull-ups, far master clock, hung slave
// --------
module i2c_bus_partner (
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic frame,
    input  wire logic hang,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ps;

    logic ext_scl = 1'b1;
    logic hold    = 1'b0;
    int   rises   = 0;

    // far clock, 64 ns period, parked high outside frames
    always begin
        #32;
        ext_scl = frame ? ~ext_scl : 1'b1;
    end

    // hung slave keeps sda low until nine clocks arrive
    always @(posedge hang) begin
        hold = 1'b1;
        rises = 0;
    end

    always @(posedge scl) begin
        if (hold) begin
            rises++;
            if (rises == 9) begin
                hold = 1'b0;
            end
        end
    end

    // open drain wires, released lines pulled high
    assign scl = ~scl_oe & ext_scl;
    assign sda = ~sda_oe & ~hold;
endmodule

//--- tb/i2c_link_timing_test.sv
module i2c_link_timing_test
    import i2c_timing_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       wr = 1'b0, rd = 1'b0, rem = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic       active = 1'b0, proxy = 1'b0, mreq = 1'b0, mrem = 1'b0;
    logic       frame = 1'b0, hang = 1'b0;
    logic       ce = 1'b1, act = 1'b0, ssda = 1'b1, sack = 1'b0;
    logic       rej, abort, scl_oe, sda_oe, scl_in, sda_in, bus_free;
    wire        scl, sda;
    logic [7:0] rv [6];
    int         errors = 0, checks = 0, k, ab, n, m;
    logic       lo, j;
    logic [7:0] d;

    always #2 clk = ~clk;

    i2c_link_timing #(.LINK_STEP(50), .BUS_SLOW(2000), .BUS_FAST(300)) i_dut (
        .CLK(clk), .SRST(srst), .CE(ce),
        .REG_WR(wr), .REG_RD(rd), .REG_REMOTE(rem),
        .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_WR_REJECT(rej),
        .LINK_TXN_ACTIVE(active), .LINK_TXN_ABORT(abort),
        .PROXY_MASTER_EN(proxy), .MASTER_REQ(mreq),
        .MASTER_REMOTE(mrem), .SLV_ACTIVE(act), .SLV_SDA(ssda),
        .SLV_ACK(sack), .SCL_I(scl), .SDA_I(sda),
        .SCL_O(), .SCL_OE(scl_oe), .SDA_O(), .SDA_OE(sda_oe),
        .SCL_IN(scl_in), .SDA_IN(sda_in), .BUS_FREE(bus_free)
    );

    i2c_bus_partner i_bus (
        .scl_oe(scl_oe), .sda_oe(sda_oe), .frame(frame),
        .hang(hang), .scl(scl), .sda(sda)
    );

    // --------
    // helpers
    // --------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v,
                          input logic r);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        rem <= r;
        @(posedge clk);
        wr <= 1'b0;
        rem <= 1'b0;
        #1 j = rej;
    endtask

    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // counts scl pulls and abort pulses, flags any filtered scl low
    task automatic sample(input int cyc);
        logic p;
        p = scl_oe;
        k = 0;
        ab = 0;
        lo = 1'b0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            k += int'(scl_oe === 1'b1 && p === 1'b0);
            ab += int'(abort === 1'b1);
            lo |= (scl_in === 1'b0);
            p = scl_oe;
        end
    endtask

    task automatic run_len(input logic lvl, output int c);
        c = 0;
        while (scl_oe === lvl && c < 4000) begin
            @(posedge clk);
            #1;
            c++;
        end
        if (c >= 4000) begin
            errors++;
            conclude();
        end
    endtask

    // --------
    // tests
    // --------
    initial begin
        rv = '{RST_LINK_WDOG, RST_CTL1, RST_CTL2, RST_SCL_PERIOD,
               RST_SCL_PERIOD, 8'h00};
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            reg_rd(8'h07 + 8'(i));
            check(d, rv[i]);
        end
        for (int i = 0; i < 6; i++) begin
            reg_wr(8'h07 + 8'(i), 8'h5a ^ 8'(i), 1'b0);
            reg_rd(8'h07 + 8'(i));
            check(d, (i < 5) ? 8'h5a ^ 8'(i) : 8'h00);
        end
        ce <= 1'b0;
        reg_wr(8'h0b, 8'h11, 1'b0);
        ce <= 1'b1;
        reg_rd(8'h0b);
        check(d, 8'h5e);
        $display("test registers done");
        reg_wr(8'h0a, 8'h33, 1'b1);
        check(j, 1'b0);
        reg_wr(8'h08, 8'h9c, 1'b0);
        reg_wr(8'h0a, 8'h44, 1'b1);
        check(j, 1'b1);
        reg_rd(8'h0a);
        check(d, 8'h33);
        $display("test lockout done");
        reg_wr(8'h07, 8'h06, 1'b0);
        reg_wr(8'h08, 8'h1c, 1'b0);
        reg_wr(8'h09, 8'h12, 1'b0);
        reg_wr(8'h0a, 8'h02, 1'b0);
        reg_wr(8'h0b, 8'h06, 1'b0);
        @(posedge clk);
        active <= 1'b1;
        n = 0;
        while (abort !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        active <= 1'b0;
        check(n >= 149 && n <= 152, 1'b1);
        reg_wr(8'h07, 8'h07, 1'b0);
        active <= 1'b1;
        sample(400);
        active <= 1'b0;
        check(16'(ab), 16'h0);
        $display("test link watchdog done");
        frame <= 1'b1;
        sample(200);
        check(lo, 1'b0);
        reg_wr(8'h08, 8'h12, 1'b0);
        sample(200);
        check(lo, 1'b1);
        check(bus_free, 1'b0);
        frame <= 1'b0;
        n = 0;
        while (bus_free !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n >= 295 && n <= 345, 1'b1);
        reg_wr(8'h09, 8'h13, 1'b0);
        frame <= 1'b1;
        sample(100);
        frame <= 1'b0;
        sample(700);
        check(bus_free, 1'b0);
        $display("test bus watchdog done");
        reg_wr(8'h09, 8'h12, 1'b0);
        mreq <= 1'b1;
        run_len(1'b0, n);
        run_len(1'b1, n);
        run_len(1'b0, m);
        mreq <= 1'b0;
        check(n >= 89 && n <= 101, 1'b1);
        check(m >= 49 && m <= 61, 1'b1);
        sample(300);
        mreq <= 1'b1;
        mrem <= 1'b1;
        sample(400);
        check(16'(k), 16'h0);
        proxy <= 1'b1;
        sample(400);
        check(k > 0, 1'b1);
        mreq <= 1'b0;
        sample(300);
        $display("test master done");
        reg_wr(8'h09, 8'h16, 1'b0);
        act <= 1'b1;
        ssda <= 1'b0;
        frame <= 1'b1;
        run_len(1'b0, n);
        run_len(1'b1, n);
        check(n >= 160 && n <= 170, 1'b1);
        check(sda_oe, 1'b1);
        check(sda_in, 1'b0);
        sack <= 1'b1;
        ssda <= 1'b1;
        run_len(1'b0, n);
        run_len(1'b1, n);
        check(n >= 240 && n <= 250, 1'b1);
        check(sda_oe, 1'b0);
        act <= 1'b0;
        frame <= 1'b0;
        sample(300);
        $display("test slave done");
        hang <= 1'b1;
        sample(3000);
        hang <= 1'b0;
        check(16'(k), 16'h9);
        $display("test recovery done");
        conclude();
    end
endmodule
